// ==== rtl/ccms_pkg.sv ====
/*
 * Package for the CPU clock mode selector: strap codes, clock source enumeration,
 * watchdog limits and the packed carriers used by the selector.
 * Assumes a single reference clock domain at 100 MHz.
 */
package ccms_pkg;

    // strap code width and codes
    localparam int STRAP_W = 3;
    localparam logic [2:0] CODE_X4 = 3'h7;
    localparam logic [2:0] CODE_X3 = 3'h6;
    localparam logic [2:0] CODE_X8 = 3'h5;
    localparam logic [2:0] CODE_X5 = 3'h4;
    localparam logic [2:0] CODE_DIRECT = 3'h3;
    localparam logic [2:0] CODE_X10 = 3'h2;
    localparam logic [2:0] CODE_PRESCALE = 3'h1;
    localparam logic [2:0] CODE_RESERVED = 3'h0;
    localparam logic [2:0] CODE_DEFAULT = CODE_X4;

    // edges after release until the strap synchroniser holds pin levels again
    localparam logic [1:0] SYNC_SETTLE = 2'h2;

    // multiply factor field
    localparam int FACTOR_W = 4;
    localparam logic [3:0] FACT_NONE = 4'h0;
    localparam logic [3:0] FACT_1 = 4'h1;
    localparam logic [3:0] FACT_3 = 4'h3;
    localparam logic [3:0] FACT_4 = 4'h4;
    localparam logic [3:0] FACT_5 = 4'h5;
    localparam logic [3:0] FACT_8 = 4'h8;
    localparam logic [3:0] FACT_10 = 4'hA;

    // system configuration bit position of the watchdog disable
    localparam int OWD_DIS_BIT = 4;

    // watchdog overflow after this many free-running clocks
    localparam int WDOG_LIMIT = 16;
    localparam int WDOG_W = 5;
    localparam logic [4:0] WDOG_LAST = 5'h0F;

    // clock source selections
    typedef enum logic [2:0] {
        CCMS_SRC_PLL = 3'b000,
        CCMS_SRC_DIRECT = 3'b001,
        CCMS_SRC_PRESCALE = 3'b010,
        CCMS_SRC_FREERUN = 3'b011,
        CCMS_SRC_OFF = 3'b100
    } ccms_src_t;

    // decoded mode carried to the consumers
    typedef struct packed {
        logic [2:0] code;
        logic [3:0] factor;
        logic pllEnable;
        logic oscBypass;
        logic prescale;
        logic reserved;
    } ccms_mode_t;

    // watchdog related outputs
    typedef struct packed {
        logic pllFreeRun;
        logic pllPowerOff;
        logic wdogIrq;
        logic failSwitched;
    } ccms_wdog_t;

endpackage : ccms_pkg

// ==== rtl/ccms_wdog_counter.sv ====
/*
 * Oscillator watchdog counter: counts free-running clock ticks and clears
 * on every transition of the input clock sample. Flags overflow once.
 * Assumes inputs already synchronous to ref_clk.
 */
`timescale 1ns/1ps
`default_nettype none

module ccms_wdog_counter (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic clkEn,
    // counting control
    input wire logic countEnable,
    input wire logic freeRunTick,
    input wire logic inputEdge,
    // result
    output logic overflow
);

    typedef struct packed {
        logic [4:0] count;
        logic ovf;
    } ccms_wcnt_t;

    ccms_wcnt_t state_reg;
    ccms_wcnt_t state_next;

    // count free-running ticks, clear on input clock edge
    always_comb
    begin
        state_next = state_reg;
        if (!countEnable || inputEdge)
        begin
            state_next.count = '0;
        end
        else if (freeRunTick && !state_reg.ovf)
        begin
            if (state_reg.count == ccms_pkg::WDOG_LAST)
            begin
                state_next.ovf = 1'b1;
            end
            else
            begin
                state_next.count = state_reg.count + 5'h01;
            end
        end
    end

    // state register
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_reg <= '0;
        end
        else if (clkEn)
        begin
            state_reg <= state_next;
        end
    end

    assign overflow = state_reg.ovf;

    // overflow needs sixteen ticks without an input edge
    chk_ovf_needs_ticks: assert property (@(posedge ref_clk) disable iff (!rst_b)
        $rose(state_reg.ovf) |-> $past(state_reg.count) == ccms_pkg::WDOG_LAST)
        else $error("watchdog overflow without full count");

endmodule : ccms_wdog_counter

`default_nettype wire

// ==== rtl/ccms_clock_select.sv ====
/*
 * CPU clock mode selector: samples the three strap pins after reset release,
 * latches the code on the third edge after release, decodes the mode, makes the prescaled
 * CPU clock enable and runs the oscillator watchdog in non-PLL modes.
 * Assumes ref_clk at 100 MHz; strap and oscillator sample pins are async.
 */
// Notes on behaviour
// - strap code sampled while reset held; sampled after release here
// - codes map to x4,x3,x8,x5,x10; 000 reserved
// - code 001 selects divide-by-two prescaler
// - prescaler phases each one input period
// - work may launch on either edge
// - timing unit is one half period; after failover it is one full free-run period
// - non-PLL: PLL free-runs unless disable set
// - external clock only in direct drive
// - direct drive bypasses PLL and amplifier
// - watchdog on after reset; bit four disables
// - count free-run ticks, overflow switches clock
`timescale 1ns/1ps
`default_nettype none

module ccms_clock_select (
    // clock, reset, enable
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic clkEn,
    // board side
    input wire logic [2:0] clockModeStrapPins,
    input wire logic oscInput,
    input wire logic freeRunClk,
    // system configuration
    input wire logic [7:0] systemConfigRegister,
    // consumers
    output ccms_pkg::ccms_mode_t modeOut,
    output ccms_pkg::ccms_wdog_t wdogOut,
    output logic cpuClkEnable,
    output logic cpuClkLevel,
    output logic halfPeriodUnit,
    output ccms_pkg::ccms_src_t clkSource
);

    ////////////////////////////////////////////////////////////////////////
    // state
    typedef struct packed {
        logic [2:0] strapMeta;
        logic [2:0] strapSync;
        logic [1:0] settle;
        logic [1:0] oscMeta;
        logic [1:0] oscSync;
        logic oscLast;
        logic frLast;
        logic started;
        logic [2:0] code;
        ccms_pkg::ccms_mode_t mode;
        ccms_pkg::ccms_wdog_t wdog;
        logic cpuEn;
        logic cpuLvl;
        logic half_period_unit;
        ccms_pkg::ccms_src_t src;
    } ccms_state_t;

    ccms_state_t state_reg;
    ccms_state_t state_next;
    logic wdogOverflow;
    logic oscEdge;
    logic frTick;
    logic owdDisable;
    logic nonPll;

    // decode a strap code into mode fields
    function automatic ccms_pkg::ccms_mode_t decodeMode(input logic [2:0] c);
        ccms_pkg::ccms_mode_t m;
        m = '0;
        m.code = c;
        m.pllEnable = 1'b1;
        unique case (c)
            ccms_pkg::CODE_X4: m.factor = ccms_pkg::FACT_4;
            ccms_pkg::CODE_X3: m.factor = ccms_pkg::FACT_3;
            ccms_pkg::CODE_X8: m.factor = ccms_pkg::FACT_8;
            ccms_pkg::CODE_X5: m.factor = ccms_pkg::FACT_5;
            ccms_pkg::CODE_X10: m.factor = ccms_pkg::FACT_10;
            ccms_pkg::CODE_DIRECT:
            begin
                m.factor = ccms_pkg::FACT_1;
                m.pllEnable = 1'b0;
                m.oscBypass = 1'b1;
            end
            ccms_pkg::CODE_PRESCALE:
            begin
                m.factor = ccms_pkg::FACT_NONE;
                m.pllEnable = 1'b0;
                m.prescale = 1'b1;
            end
            ccms_pkg::CODE_RESERVED:
            begin
                m.factor = ccms_pkg::FACT_NONE;
                m.pllEnable = 1'b0;
                m.reserved = 1'b1;
            end
        endcase
        return m;
    endfunction : decodeMode

    assign oscEdge = state_reg.oscSync[0] ^ state_reg.oscLast;
    assign frTick = state_reg.oscSync[1] & ~state_reg.frLast;
    assign owdDisable = systemConfigRegister[ccms_pkg::OWD_DIS_BIT];
    assign nonPll = state_reg.mode.oscBypass | state_reg.mode.prescale;

    ////////////////////////////////////////////////////////////////////////
    // watchdog counter
    ccms_wdog_counter uWdog (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .clkEn(clkEn),
        .countEnable(state_reg.started & nonPll & ~owdDisable),
        .freeRunTick(frTick),
        .inputEdge(oscEdge),
        .overflow(wdogOverflow)
    );

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb
    begin
        state_next = state_reg;
        // two-stage synchronisers; bit1 of osc pair carries the free-run clock
        state_next.strapMeta = clockModeStrapPins;
        state_next.strapSync = state_reg.strapMeta;
        state_next.oscMeta = {freeRunClk, oscInput};
        state_next.oscSync = state_reg.oscMeta;
        state_next.oscLast = state_reg.oscSync[0];
        state_next.frLast = state_reg.oscSync[1];
        // latch code once the synchroniser, cleared by reset, holds pin levels
        if (!state_reg.started)
        begin
            if (state_reg.settle == ccms_pkg::SYNC_SETTLE)
            begin
                state_next.started = 1'b1;
                state_next.code = state_reg.strapSync;
                state_next.mode = decodeMode(state_reg.strapSync);
            end
            else
            begin
                state_next.settle = state_reg.settle + 2'h1;
            end
        end
        // watchdog outputs in non-PLL modes
        state_next.wdog.pllFreeRun = state_reg.started & nonPll & ~owdDisable;
        state_next.wdog.pllPowerOff = state_reg.started & nonPll & owdDisable;
        if (wdogOverflow)
        begin
            state_next.wdog.failSwitched = 1'b1;
            state_next.wdog.wdogIrq = 1'b1;
        end
        // cpu clock: PLL and direct take each input edge as one half period unit; prescale uses rising edges only, failover rising free-run edges
        state_next.cpuEn = 1'b0;
        state_next.half_period_unit = 1'b0;
        if (!state_reg.started)
        begin
            state_next.src = ccms_pkg::CCMS_SRC_OFF;
        end
        else if (state_reg.wdog.failSwitched)
        begin
            state_next.src = ccms_pkg::CCMS_SRC_FREERUN;
            state_next.cpuLvl = state_reg.oscSync[1];
            state_next.half_period_unit = frTick;
            state_next.cpuEn = frTick;
        end
        else if (state_reg.mode.prescale)
        begin
            state_next.src = ccms_pkg::CCMS_SRC_PRESCALE;
            // toggle on each rising input edge: one input period per phase
            if (oscEdge && state_reg.oscSync[0])
            begin
                state_next.half_period_unit = 1'b1;
                state_next.cpuLvl = ~state_reg.cpuLvl;
                state_next.cpuEn = 1'b1;
            end
        end
        else if (state_reg.mode.oscBypass)
        begin
            state_next.src = ccms_pkg::CCMS_SRC_DIRECT;
            state_next.cpuLvl = state_reg.oscSync[0];
            state_next.half_period_unit = oscEdge;
            state_next.cpuEn = oscEdge;
        end
        else if (state_reg.mode.reserved)
        begin
            state_next.src = ccms_pkg::CCMS_SRC_OFF;
        end
        else
        begin
            state_next.src = ccms_pkg::CCMS_SRC_PLL;
            state_next.cpuLvl = state_reg.oscSync[0];
            state_next.half_period_unit = oscEdge;
            state_next.cpuEn = oscEdge;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_reg <= '0;
            state_reg.code <= ccms_pkg::CODE_DEFAULT;
            state_reg.src <= ccms_pkg::CCMS_SRC_OFF;
        end
        else if (clkEn)
        begin
            state_reg <= state_next;
        end
    end

    // outputs straight from flops
    assign modeOut = state_reg.mode;
    assign wdogOut = state_reg.wdog;
    assign cpuClkEnable = state_reg.cpuEn;
    assign cpuClkLevel = state_reg.cpuLvl;
    assign halfPeriodUnit = state_reg.half_period_unit;
    assign clkSource = state_reg.src;

    ////////////////////////////////////////////////////////////////////////
    // checks
    chk_code_frozen: assert property (@(posedge ref_clk) disable iff (!rst_b)
        $past(state_reg.started) |-> $stable(state_reg.code))
        else $error("latched code changed after start");

    chk_code_sampled: assert property (@(posedge ref_clk) disable iff (!rst_b)
        clkEn && !state_reg.started && state_reg.settle == ccms_pkg::SYNC_SETTLE
        |=> state_reg.code == $past(state_reg.strapSync))
        else $error("strap code not captured");

    chk_prescale_src: assert property (@(posedge ref_clk) disable iff (!rst_b)
        state_reg.started && state_reg.mode.prescale && !state_reg.wdog.failSwitched && clkEn
        |=> state_reg.src == ccms_pkg::CCMS_SRC_PRESCALE)
        else $error("prescale mode not routed");

    chk_prescale_phase: assert property (@(posedge ref_clk) disable iff (!rst_b)
        state_reg.src == ccms_pkg::CCMS_SRC_PRESCALE && $changed(state_reg.cpuLvl)
        |-> state_reg.half_period_unit)
        else $error("prescaler phase without input period");

    chk_direct_nopll: assert property (@(posedge ref_clk) disable iff (!rst_b)
        state_reg.mode.oscBypass |-> !state_reg.mode.pllEnable
        && state_reg.mode.factor == ccms_pkg::FACT_1)
        else $error("direct drive keeps pll");

    chk_pll_power: assert property (@(posedge ref_clk) disable iff (!rst_b)
        state_reg.started && clkEn
        |=> (state_reg.wdog.pllPowerOff == (nonPll && $past(owdDisable)))
        && (state_reg.wdog.pllFreeRun == (nonPll && !$past(owdDisable))))
        else $error("pll both running and off");

    chk_fail_sticky: assert property (@(posedge ref_clk) disable iff (!rst_b)
        state_reg.wdog.failSwitched |=> state_reg.wdog.failSwitched
        && state_reg.wdog.wdogIrq)
        else $error("watchdog switch not held");

    chk_default_x4: assert property (@(posedge ref_clk) disable iff (!rst_b)
        state_reg.started && state_reg.code == ccms_pkg::CODE_X4
        |-> state_reg.mode.factor == ccms_pkg::FACT_4)
        else $error("default code not times four");

    chk_tcl_edge: assert property (@(posedge ref_clk) disable iff (!rst_b)
        state_reg.src == ccms_pkg::CCMS_SRC_DIRECT && clkEn && !state_reg.wdog.failSwitched
        |=> halfPeriodUnit == $past(oscEdge))
        else $error("half period unit not on input edge");

endmodule : ccms_clock_select

`default_nettype wire

// ==== bench/ccms_board_model.sv ====
/*
 * Board side model: strap pin levels, crystal oscillator and the PLL
 * free-running clock as seen by the clock mode selector.
 * Assumes ref_clk at 100 MHz; the bench sets strap level and osc run.
 */
`timescale 1ns/1ps
`default_nettype none

module ccms_board_model #(
    parameter int OSC_HALF = 8,
    parameter int FR_HALF = 2
) (
    // clock
    input wire logic ref_clk,
    // bench control
    input wire logic [2:0] strapSet,
    input wire logic oscRun,
    input wire logic pllOff,
    // pins
    output logic [2:0] strapPins,
    output logic oscPin,
    output logic freeRunPin
);
    int oscCnt = 0;
    int frCnt = 0;
    logic oscLvl = 1'b0;
    logic frLvl = 1'b0;

    // strap levels held steady by the board through reset
    assign strapPins = strapSet;
    assign oscPin = oscLvl;
    assign freeRunPin = frLvl;

    ////////////////////////////////////////////////////////////////////
    // crystal stops on failure, free-run stops when powered off
    always @(posedge ref_clk)
    begin
        oscCnt <= (oscCnt + 1) % OSC_HALF;
        frCnt <= (frCnt + 1) % FR_HALF;
        if (oscRun && oscCnt == OSC_HALF - 1)
            oscLvl <= ~oscLvl;
        if (!pllOff && frCnt == FR_HALF - 1)
            frLvl <= ~frLvl;
    end
endmodule : ccms_board_model
`default_nettype wire

// ==== bench/ccms_clock_select_tb_top.sv ====
/*
 * Self-checking bench for the clock mode selector: decode of every code,
 * latch after reset, edge spacing and oscillator watchdog failover.
 * Assumes the board model beside it and a single 100 MHz clock.
 */
`timescale 1ns/1ps
`default_nettype none

module ccms_clock_select_tb_top;
    localparam int OSC_HALF = 8;
    localparam logic [3:0] EXP_FACT [8] = '{4'h0, 4'h0, ccms_pkg::FACT_10,
        ccms_pkg::FACT_1, ccms_pkg::FACT_5, ccms_pkg::FACT_8,
        ccms_pkg::FACT_3, ccms_pkg::FACT_4};
    logic ref_clk;
    logic rst_b;
    logic clkEn;
    logic oscRun;
    logic [2:0] strapSet;
    logic [2:0] strapPins;
    logic oscPin;
    logic freeRunPin;
    logic [7:0] sysCfg;
    ccms_pkg::ccms_mode_t modeOut;
    ccms_pkg::ccms_wdog_t wdogOut;
    logic cpuClkEnable;
    logic cpuClkLevel;
    logic halfPeriodUnit;
    ccms_pkg::ccms_src_t clkSource;
    int miscompares = 0;
    int compares = 0;

    ////////////////////////////////////////////////////////////////////
    // design and board
    ccms_clock_select dut (.ref_clk(ref_clk), .rst_b(rst_b), .clkEn(clkEn),
        .clockModeStrapPins(strapPins), .oscInput(oscPin),
        .freeRunClk(freeRunPin), .systemConfigRegister(sysCfg),
        .modeOut(modeOut), .wdogOut(wdogOut), .cpuClkEnable(cpuClkEnable),
        .cpuClkLevel(cpuClkLevel), .halfPeriodUnit(halfPeriodUnit),
        .clkSource(clkSource));
    ccms_board_model #(.OSC_HALF(OSC_HALF), .FR_HALF(2)) board (
        .ref_clk(ref_clk), .strapSet(strapSet), .oscRun(oscRun),
        .pllOff(wdogOut.pllPowerOff), .strapPins(strapPins),
        .oscPin(oscPin), .freeRunPin(freeRunPin));

    ////////////////////////////////////////////////////////////////////
    // shared tasks
    task automatic wait_cycles(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : wait_cycles

    task automatic check(input logic ok, input string msg);
        compares++;
        if (ok !== 1'b1)
        begin
            miscompares++;
            $display("ERROR %0t %s", $time, msg);
        end
    endtask : check

    task automatic complete_run();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : complete_run

    task automatic do_reset(input logic [2:0] code, input logic [7:0] cfg);
        @(posedge ref_clk);
        rst_b <= 1'b0;
        strapSet <= code;
        sysCfg <= cfg;
        oscRun <= 1'b1;
        wait_cycles(8);
        check(modeOut === '0 && clkSource === ccms_pkg::CCMS_SRC_OFF, "rst");
        rst_b <= 1'b1;
        wait_cycles(6);
    endtask : do_reset

    task automatic wait_pulse(inout int n);
        do
        begin
            wait_cycles(1);
            n++;
        end
        while (cpuClkEnable !== 1'b1 && n < 300);
    endtask : wait_pulse

    ////////////////////////////////////////////////////////////////////
    // every code decoded, watchdog power per disable bit
    task automatic test_decode();
        logic [2:0] c;
        logic nonPll;
        for (int i = 0; i < 8; i++)
        begin
            c = i[2:0];
            nonPll = (c == 3'h1 || c == 3'h3);
            do_reset(c, 8'h00);
            check(modeOut.code === c, "code");
            check(modeOut.reserved === (c == 3'h0), "reserved");
            if (c > 3'h1)
                check(modeOut.factor === EXP_FACT[i], "factor");
            check(modeOut.pllEnable === (c > 3'h1 && c != 3'h3), "pll");
            check(modeOut.oscBypass === (c == 3'h3), "bypass");
            check(modeOut.prescale === (c == 3'h1), "prescale");
            check(clkSource === (c == 3'h0 ? ccms_pkg::CCMS_SRC_OFF :
                c == 3'h1 ? ccms_pkg::CCMS_SRC_PRESCALE :
                c == 3'h3 ? ccms_pkg::CCMS_SRC_DIRECT : ccms_pkg::CCMS_SRC_PLL),
                "source");
            if (nonPll)
            begin
                check(wdogOut.pllFreeRun === 1'b1, "free run");
                check(wdogOut.pllPowerOff === 1'b0, "power");
                do_reset(c, 8'h10);
                check(wdogOut.pllPowerOff === 1'b1, "off");
                check(wdogOut.pllFreeRun === 1'b0, "no run");
            end
        end
    endtask : test_decode

    // strap moves after release are ignored
    task automatic test_latch();
        do_reset(ccms_pkg::CODE_X5, 8'h00);
        strapSet <= ccms_pkg::CODE_DIRECT;
        wait_cycles(10);
        check(modeOut.code === ccms_pkg::CODE_X5, "frozen");
        check(clkSource === ccms_pkg::CCMS_SRC_PLL, "src frozen");
    endtask : test_latch

    // spacing of cpu clock edges and level flips
    task automatic test_tcl(input logic [2:0] code, input int gap);
        int n;
        logic lvl;
        logic prev;
        do_reset(code, 8'h00);
        n = 0;
        wait_pulse(n);
        for (int k = 0; k < 4; k++)
        begin
            wait_cycles(gap / 2);
            lvl = cpuClkLevel;
            n = gap / 2;
            wait_pulse(n);
            check(n == gap, "edge spacing");
            check(halfPeriodUnit === 1'b1, "unit");
            if (k > 0)
                check(lvl !== prev, "level flip");
            prev = lvl;
        end
        check(wdogOut.failSwitched === 1'b0, "false fail");
    endtask : test_tcl

    // oscillator stops: failover only when watched
    task automatic test_wdog(input logic [2:0] code, input logic [7:0] cfg,
        input logic expFail, input ccms_pkg::ccms_src_t normSrc);
        int n;
        do_reset(code, cfg);
        wait_cycles(20);
        oscRun <= 1'b0;
        wait_cycles(40);
        check(wdogOut.failSwitched === 1'b0, "early fail");
        n = 0;
        while (wdogOut.failSwitched !== 1'b1 && n < 80)
        begin
            wait_cycles(1);
            n++;
        end
        check(wdogOut.failSwitched === expFail, "fail flag");
        check(wdogOut.wdogIrq === expFail, "irq flag");
        wait_cycles(2);
        oscRun <= 1'b1;
        wait_cycles(30);
        check(clkSource === (expFail ? ccms_pkg::CCMS_SRC_FREERUN : normSrc),
            "fail source");
    endtask : test_wdog

    ////////////////////////////////////////////////////////////////////
    // clock, main sequence, watchdog
    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    initial
    begin
        rst_b = 1'b0;
        clkEn = 1'b1;
        strapSet = ccms_pkg::CODE_DEFAULT;
        sysCfg = 8'h00;
        oscRun = 1'b1;
        test_decode();
        test_latch();
        test_tcl(ccms_pkg::CODE_DIRECT, OSC_HALF);
        test_tcl(ccms_pkg::CODE_PRESCALE, 2 * OSC_HALF);
        test_wdog(ccms_pkg::CODE_DIRECT, 8'h00, 1'b1, ccms_pkg::CCMS_SRC_DIRECT);
        test_wdog(ccms_pkg::CODE_PRESCALE, 8'h00, 1'b1,
            ccms_pkg::CCMS_SRC_PRESCALE);
        test_wdog(ccms_pkg::CODE_DIRECT, 8'h10, 1'b0, ccms_pkg::CCMS_SRC_DIRECT);
        test_wdog(ccms_pkg::CODE_X4, 8'h00, 1'b0, ccms_pkg::CCMS_SRC_PLL);
        complete_run();
    end

    initial
    begin
        #200us;
        miscompares++;
        complete_run();
    end
endmodule : ccms_clock_select_tb_top
`default_nettype wire
